//--- logic/stc_pkg.sv
// Constants for the three-channel system timer: host port decode, control word fields,
// counting modes and clock figures.
// Assumes a 40 MHz core clock and a slow base oscillator that arrives as a plain pin.
// Contract
// R1: Three counter channels 0..2 share the base oscillator; gates 0 and 1 always on.
// R2: Channel 0 output drives interrupt request level zero as the system tick.
// R3: Software sets channel 1 to a 15 us period; each period asks one refresh.
// R4: Channel 2 gate follows bit 0 of the system control port at 61 hex.
// R5: Channel 2 output waveform drives the speaker signal.
// R6: Four host ports: three counter ports and one mode control port.
// R7: The block answers host accesses from 040 to 05F hex inside 000..0FF.
package stc_pkg;
    // Host decode
    localparam logic [9:0] IO_BASE = 10'h040;
    localparam logic [9:0] IO_LAST = 10'h05F;
    localparam logic [9:0] IO_SYS_LAST = 10'h0FF;
    localparam logic [1:0] PORT_CTL = 2'h3;
    localparam logic [7:0] CTL_READ_VAL = 8'hFF;
    localparam int SCP_ADDR = 'h61;
    localparam int SCP_GATE_BIT = 0;
    localparam int NUM_CH = 3;

    // Control word fields
    localparam int CW_SEL_HI = 7;
    localparam int CW_SEL_LO = 6;
    localparam int CW_RW_HI = 5;
    localparam int CW_RW_LO = 4;
    localparam int CW_MODE_HI = 3;
    localparam int CW_MODE_LO = 1;
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB = 2'h1;
    localparam logic [1:0] RW_MSB = 2'h2;
    localparam logic [1:0] RW_BOTH = 2'h3;

    // Counting modes
    localparam logic [2:0] MODE_TC_EVENT = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SW_STROBE = 3'h4;
    localparam logic [2:0] MODE_HW_STROBE = 3'h5;

    // Reset values
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [1:0] RW_RST = 2'h3;

    // Timing
    localparam int CORE_HZ = 40000000;
    localparam int OSC_HZ = 1190000;
    localparam int OSC_CYCLES = CORE_HZ / OSC_HZ;
    localparam int REFRESH_PERIOD_NS = 15000;
endpackage : stc_pkg

//--- logic/stc_chan_if.sv
// Carrier between the timer top and one counter channel.
// Assumes all signals are synchronous to the core clock.
`timescale 1ns/1ps
interface stc_chan_if;
    logic ctl_wr;
    logic cnt_wr;
    logic cnt_rd;
    logic [7:0] wdata;
    logic tick;
    logic gate;
    logic [7:0] rdata;
    logic out;

    modport ctrl (
        output ctl_wr, cnt_wr, cnt_rd, wdata, tick, gate,
        input rdata, out
    );
    modport chan (
        input ctl_wr, cnt_wr, cnt_rd, wdata, tick, gate,
        output rdata, out
    );
endinterface : stc_chan_if

//--- logic/stc_channel.sv
// One programmable 16-bit down counter with six counting modes, binary only.
// Assumes tick is a one-cycle strobe per rising base oscillator edge and gate is already synchronised.
`timescale 1ns/1ps
module stc_channel
    import stc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Link to the top
    stc_chan_if.chan ch
);
    logic [2:0] mode_r;
    logic [1:0] rw_r;
    logic wr_msb_r;
    logic [15:0] reload_r;
    logic [15:0] cnt_r;
    logic run_r;
    logic pend_r;
    logic armed_r;
    logic out_r;
    logic trig_r;
    logic gate_d_r;
    logic rd_msb_r;
    logic latched_r;
    logic [15:0] latch_r;
    logic cfg;
    logic latch_cmd;
    logic full_wr;
    logic hw_mode;
    logic [15:0] start_val;
    logic [15:0] rd_src;

    assign cfg = ch.ctl_wr && ch.wdata[CW_RW_HI:CW_RW_LO] != RW_LATCH;
    assign latch_cmd = ch.ctl_wr && ch.wdata[CW_RW_HI:CW_RW_LO] == RW_LATCH;
    assign full_wr = ch.cnt_wr && (rw_r != RW_BOTH || wr_msb_r);
    assign hw_mode = mode_r == MODE_ONESHOT || mode_r == MODE_HW_STROBE;
    // Square wave halves run by twos, so the odd bit of the count is dropped
    assign start_val = (mode_r == MODE_SQUARE) ? {reload_r[15:1], 1'b0} : reload_r;

    // Programming: mode, access order and the count being written
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= MODE_RST;
            rw_r <= RW_RST;
            wr_msb_r <= 1'b0;
            reload_r <= CNT_RST;
        end else if (cfg) begin // R6
            mode_r <= (ch.wdata[3:2] == 2'h3) ? {1'b0, ch.wdata[2:1]} : ch.wdata[CW_MODE_HI:CW_MODE_LO];
            rw_r <= ch.wdata[CW_RW_HI:CW_RW_LO];
            wr_msb_r <= 1'b0;
        end else if (ch.cnt_wr) begin
            case (rw_r)
                RW_LSB: reload_r <= {8'h00, ch.wdata};
                RW_MSB: reload_r <= {ch.wdata, 8'h00};
                default: begin
                    if (wr_msb_r) begin
                        reload_r[15:8] <= ch.wdata;
                    end else begin
                        reload_r[7:0] <= ch.wdata;
                    end
                    wr_msb_r <= ~wr_msb_r;
                end
            endcase
        end
    end

    // Counting and output waveform
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= CNT_RST;
            run_r <= 1'b0;
            pend_r <= 1'b0;
            armed_r <= 1'b0;
            out_r <= 1'b0;
            trig_r <= 1'b0;
            gate_d_r <= 1'b0;
        end else begin
            gate_d_r <= ch.gate;
            if (cfg) begin
                run_r <= 1'b0;
                pend_r <= 1'b0;
                armed_r <= 1'b0;
                trig_r <= 1'b0;
                out_r <= ch.wdata[CW_MODE_HI:CW_MODE_LO] != MODE_TC_EVENT;
            end else begin
                if (full_wr) begin
                    pend_r <= 1'b1;
                    armed_r <= 1'b1;
                end
                if (ch.cnt_wr && mode_r == MODE_TC_EVENT) begin
                    run_r <= 1'b0;
                    out_r <= 1'b0;
                end
                if (ch.tick) begin
                    // A gate edge arriving on a tick is kept for the next one
                    trig_r <= ch.gate && !gate_d_r;
                    if ((pend_r && !hw_mode) || (armed_r && trig_r && mode_r != MODE_TC_EVENT
                            && mode_r != MODE_SW_STROBE)) begin
                        cnt_r <= start_val;
                        run_r <= 1'b1;
                        // A count completed on the load tick stays pending for the next one
                        pend_r <= full_wr;
                        out_r <= mode_r != MODE_TC_EVENT && mode_r != MODE_ONESHOT;
                    end else if (run_r && (ch.gate || hw_mode)) begin // R1
                        case (mode_r)
                            MODE_RATE: begin
                                cnt_r <= (cnt_r == 16'h0001) ? reload_r : cnt_r - 16'h0001;
                                out_r <= cnt_r != 16'h0002;
                            end
                            MODE_SQUARE: begin
                                if (cnt_r == 16'h0002) begin
                                    out_r <= ~out_r;
                                    cnt_r <= start_val;
                                end else begin
                                    cnt_r <= cnt_r - 16'h0002;
                                end
                            end
                            MODE_SW_STROBE, MODE_HW_STROBE: begin
                                cnt_r <= cnt_r - 16'h0001;
                                if (!out_r) begin
                                    out_r <= 1'b1;
                                    run_r <= 1'b0;
                                end else if (cnt_r == 16'h0001) begin
                                    out_r <= 1'b0;
                                end
                            end
                            default: begin
                                cnt_r <= cnt_r - 16'h0001;
                                if (cnt_r == 16'h0001) begin
                                    out_r <= 1'b1;
                                end
                            end
                        endcase
                    end
                    // Rate and square modes idle high while the gate is low
                    if (!ch.gate && (mode_r == MODE_RATE || mode_r == MODE_SQUARE)) begin
                        out_r <= 1'b1;
                    end
                end else if (ch.gate && !gate_d_r) begin
                    trig_r <= 1'b1;
                end
            end
        end
    end

    // Read side: latch command and byte order
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            latch_r <= CNT_RST;
            latched_r <= 1'b0;
            rd_msb_r <= 1'b0;
        end else if (cfg) begin
            latched_r <= 1'b0;
            rd_msb_r <= 1'b0;
        end else if (latch_cmd && !latched_r) begin
            latch_r <= cnt_r;
            latched_r <= 1'b1;
        end else if (ch.cnt_rd) begin
            if (rw_r == RW_BOTH) begin
                rd_msb_r <= ~rd_msb_r;
            end
            if (rw_r != RW_BOTH || rd_msb_r) begin
                latched_r <= 1'b0;
            end
        end
    end

    assign rd_src = latched_r ? latch_r : cnt_r;
    assign ch.rdata = (rw_r == RW_MSB || (rw_r == RW_BOTH && rd_msb_r)) ? rd_src[15:8] : rd_src[7:0];
    assign ch.out = out_r;

    a_gate_pause: assert property (@(posedge core_clk) disable iff (!rstn) // R4
        run_r && !pend_r && !trig_r && !hw_mode && !ch.gate && !cfg
        |=> $stable(cnt_r))
        else $error("count moved while gate low");
endmodule : stc_channel

//--- logic/stc_timer.sv
// Top of the three-channel system timer: host port decode, pin synchronisers,
// channel routing to the tick interrupt, refresh request and speaker.
// Assumes host strobes are one-cycle pulses on the core clock; pins are asynchronous.
`timescale 1ns/1ps
module stc_timer
    import stc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Host I/O port
    input wire logic [9:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rd_valid,
    // Pins
    input wire logic base_oscillator,
    input wire logic scp_tone_gate,
    // Outputs to the system
    output logic irq0,
    output logic refresh_req,
    output logic speaker
);
    logic [2:0] osc_sync_r;
    logic osc_lvl_r;
    logic tick_r;
    logic [2:0] gate_sync_r;
    logic gate_lvl_r;
    logic hit;
    logic [1:0] port;
    logic [7:0] io_rdata_r;
    logic io_rd_valid_r;
    logic irq0_r;
    logic refresh_req_r;
    logic ref_d_r;
    logic speaker_r;
    logic [7:0] ch_rdata [NUM_CH];
    logic ch_out [NUM_CH];

    stc_chan_if chif [NUM_CH] ();

    // Base oscillator: a level is accepted once the last two stages agree
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            osc_sync_r <= 3'h0;
            osc_lvl_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            osc_sync_r <= {osc_sync_r[1:0], base_oscillator};
            tick_r <= 1'b0;
            if (osc_sync_r[1] == osc_sync_r[2]) begin
                osc_lvl_r <= osc_sync_r[2];
                tick_r <= osc_sync_r[2] && !osc_lvl_r; // R1
            end
        end
    end

    // Tone gate from the system control port, bit 0
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gate_sync_r <= 3'h0;
            gate_lvl_r <= 1'b0;
        end else begin
            gate_sync_r <= {gate_sync_r[1:0], scp_tone_gate};
            if (gate_sync_r[1] == gate_sync_r[2]) begin
                gate_lvl_r <= gate_sync_r[2]; // R4
            end
        end
    end

    // Decode: the 32-byte window aliases the four ports
    assign hit = io_addr >= IO_BASE && io_addr <= IO_LAST; // R7
    assign port = io_addr[1:0];

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        assign chif[i].ctl_wr = io_wr && hit && port == PORT_CTL
            && io_wdata[CW_SEL_HI:CW_SEL_LO] == 2'(i); // R6
        assign chif[i].cnt_wr = io_wr && hit && port == 2'(i);
        assign chif[i].cnt_rd = io_rd && hit && port == 2'(i);
        assign chif[i].wdata = io_wdata;
        assign chif[i].tick = tick_r;
        // Gates 0 and 1 are tied on
        assign chif[i].gate = (i == 2) ? gate_lvl_r : 1'b1; // R1 R4
        assign ch_rdata[i] = chif[i].rdata;
        assign ch_out[i] = chif[i].out;

        stc_channel u_ch (
            .core_clk(core_clk),
            .rstn(rstn),
            .ch(chif[i])
        );
    end

    // Host read answer one cycle after the strobe
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            io_rdata_r <= 8'h00;
            io_rd_valid_r <= 1'b0;
        end else begin
            io_rd_valid_r <= io_rd && hit; // R7
            if (io_rd && hit) begin
                case (port)
                    2'h0: io_rdata_r <= ch_rdata[0];
                    2'h1: io_rdata_r <= ch_rdata[1];
                    2'h2: io_rdata_r <= ch_rdata[2];
                    default: io_rdata_r <= CTL_READ_VAL;
                endcase
            end
        end
    end

    // System outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq0_r <= 1'b0;
            speaker_r <= 1'b0;
            ref_d_r <= 1'b0;
            refresh_req_r <= 1'b0;
        end else begin
            irq0_r <= ch_out[0]; // R2
            speaker_r <= ch_out[2]; // R5
            ref_d_r <= ch_out[1];
            // One refresh request per period of channel 1
            refresh_req_r <= ch_out[1] && !ref_d_r; // R3
        end
    end

    assign io_rdata = io_rdata_r;
    assign io_rd_valid = io_rd_valid_r;
    assign irq0 = irq0_r;
    assign refresh_req = refresh_req_r;
    assign speaker = speaker_r;

    a_irq_follow: assert property (@(posedge core_clk) disable iff (!rstn) // R2
        $rose(ch_out[0]) |=> irq0 ##1 $stable(irq0) || !ch_out[0])
        else $error("tick interrupt did not follow channel 0");

    a_spk_follow: assert property (@(posedge core_clk) disable iff (!rstn) // R5
        ##1 speaker == $past(ch_out[2]))
        else $error("speaker does not follow channel 2");

    a_rd_answer: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        io_rd && io_addr >= IO_BASE && io_addr <= IO_LAST |=> io_rd_valid ##1 !io_rd_valid || $past(io_rd))
        else $error("read in timer range got no answer");

    a_rd_outside: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        io_rd && (io_addr < IO_BASE || io_addr > IO_LAST) |=> !io_rd_valid)
        else $error("read outside timer range answered");

    a_ctl_port: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        io_wr && io_addr[1:0] == 2'h3 && hit |-> !chif[0].cnt_wr && !chif[1].cnt_wr && !chif[2].cnt_wr)
        else $error("control write reached a counter port");

    a_tick_spacing: assert property (@(posedge core_clk) disable iff (!rstn) // R1
        tick_r |=> !tick_r [*3])
        else $error("oscillator ticks too close");

    a_gate_sync: assert property (@(posedge core_clk) disable iff (!rstn) // R4
        scp_tone_gate [*5] |-> gate_lvl_r ##1 chif[2].gate)
        else $error("tone gate did not follow the control port bit");

    // Routing guards; some hold by construction to catch later breakage
    a_refresh_once: assert property (@(posedge core_clk) disable iff (!rstn) // R3
        refresh_req |=> !refresh_req)
        else $error("refresh request longer than one cycle");

    a_refresh_rise: assert property (@(posedge core_clk) disable iff (!rstn) // R3
        $rose(ch_out[1]) |=> refresh_req)
        else $error("channel 1 rise gave no refresh request");

    a_irq_fall: assert property (@(posedge core_clk) disable iff (!rstn) // R2
        $fell(ch_out[0]) |=> !irq0)
        else $error("tick interrupt did not drop with channel 0");

    a_rd_ctl_data: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        io_rd && hit && port == PORT_CTL |=> io_rdata == CTL_READ_VAL)
        else $error("control port read did not return the fixed value");

    a_rd_ch0_data: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        io_rd && hit && port == 2'h0 |=> io_rdata == $past(ch_rdata[0]))
        else $error("counter 0 read data lost");

    a_rd_ch1_data: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        io_rd && hit && port == 2'h1 |=> io_rdata == $past(ch_rdata[1]))
        else $error("counter 1 read data lost");

    a_rd_ch2_data: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        io_rd && hit && port == 2'h2 |=> io_rdata == $past(ch_rdata[2]))
        else $error("counter 2 read data lost");

    a_rdata_hold: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        !(io_rd && hit) |=> $stable(io_rdata))
        else $error("read data moved without an accepted read");

    a_wr_quiet: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        io_wr && !io_rd |=> !io_rd_valid)
        else $error("write produced a read answer");

    a_outside_quiet: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        io_wr && !hit |-> !chif[0].cnt_wr && !chif[1].cnt_wr && !chif[2].cnt_wr
            && !chif[0].ctl_wr && !chif[1].ctl_wr && !chif[2].ctl_wr)
        else $error("write outside timer range reached a channel");

    a_readback_ignored: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        io_wr && hit && port == PORT_CTL && io_wdata[CW_SEL_HI:CW_SEL_LO] == 2'h3
            |-> !chif[0].ctl_wr && !chif[1].ctl_wr && !chif[2].ctl_wr)
        else $error("read back control word reached a channel");

    a_ctl_onehot: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        $onehot0({chif[0].ctl_wr, chif[1].ctl_wr, chif[2].ctl_wr}))
        else $error("control word selected more than one channel");

    a_tick_level: assert property (@(posedge core_clk) disable iff (!rstn) // R1
        tick_r |-> osc_lvl_r)
        else $error("tick without a high oscillator level");

    a_gates_tied: assert property (@(posedge core_clk) disable iff (!rstn) // R1
        chif[0].gate && chif[1].gate)
        else $error("gate of channel 0 or 1 not held on");

    a_gate_low: assert property (@(posedge core_clk) disable iff (!rstn) // R4
        !scp_tone_gate [*5] |-> !gate_lvl_r)
        else $error("tone gate stayed on after the control port bit cleared");
endmodule : stc_timer

//--- bench/stc_host_model.sv
// Host processor model: byte-wide I/O port writes and reads on the timer's host port.
// Assumes one-cycle strobes launched just after a core clock edge, one access at a time.
`timescale 1ns/1ps
module stc_host_model
    import stc_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Host I/O port
    output logic [9:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rd_valid
);
    initial begin
        io_addr = 10'h3FF;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'hA5;
    end

    task automatic io_write(input logic [9:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        io_addr <= addr;
        io_wdata <= data;
        io_wr <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
        // Released lines carry junk so a stale value is never mistaken for a fresh one
        io_addr <= ~addr;
        io_wdata <= ~data;
    endtask : io_write

    task automatic io_read(input logic [9:0] addr, output logic valid, output logic [7:0] data);
        @(posedge core_clk);
        io_addr <= addr;
        io_rd <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        io_addr <= ~addr;
        // The answer stands for the one cycle after the strobe edge
        #1;
        valid = io_rd_valid;
        data = io_rdata;
    endtask : io_read

    // Control word, then the count LSB first and MSB second
    task automatic load_channel(input logic [9:0] base, input logic [1:0] ch, input logic [7:0] ctl,
                           input logic [15:0] cnt);
        io_write(base + 10'h003, ctl);
        io_write(base + {8'h00, ch}, cnt[7:0]);
        io_write(base + {8'h00, ch}, cnt[15:8]);
    endtask : load_channel

    // Rate mode on channel 1 with 18 oscillator ticks, close to a 15 us refresh period
    task automatic program_refresh();
        load_channel(IO_BASE, 2'h1, 8'h74, 16'h0012);
    endtask : program_refresh
endmodule : stc_host_model

//--- bench/stc_timer_test.sv
// Self-checking bench for the three-channel system timer.
// Assumes the host model above and a bench-made oscillator of 34 core cycles per period.
`timescale 1ns/1ps
module stc_timer_test
    import stc_pkg::*;
;
    localparam int OSC_HALF = 17;
    localparam int OSC_PER = 2 * OSC_HALF;
    localparam int LIMIT = 40000;
    logic core_clk, rstn, base_oscillator, scp_tone_gate;
    logic [9:0] io_addr;
    logic io_wr, io_rd, io_rd_valid, irq0, refresh_req, speaker;
    logic [7:0] io_wdata, io_rdata;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int osc_cnt = 0;
    int seed;

    stc_timer u_dut (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid), .base_oscillator(base_oscillator),
        .scp_tone_gate(scp_tone_gate), .irq0(irq0), .refresh_req(refresh_req), .speaker(speaker));
    stc_host_model u_host (.core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (osc_cnt == OSC_HALF - 1) begin
            osc_cnt <= 0;
            base_oscillator <= ~base_oscillator;
        end else begin
            osc_cnt <= osc_cnt + 1;
        end
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("[FAIL] run length expected finish seen hang");
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Summary: %0d comparisons, %0d mismatches", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // Reference model: rate mode repeats every count ticks, square mode drops the odd bit
    function automatic int model_period(input int mode, input int cnt);
        model_period = ((mode == 3) ? (cnt & ~1) : cnt) * OSC_PER;
    endfunction : model_period

    function automatic logic pick(input int which);
        case (which)
            0: pick = irq0;
            1: pick = refresh_req;
            default: pick = speaker;
        endcase
    endfunction : pick

    // Gap between the second and third rising edge; the first period after a load may be short
    task automatic period(input int which, output int gap);
        int n;
        int hits;
        int last;
        logic prev;
        hits = 0;
        last = 0;
        gap = -1;
        prev = pick(which);
        for (n = 0; n < 5000 && gap < 0; n++) begin
            @(posedge core_clk);
            #1;
            if (pick(which) === 1'b1 && prev === 1'b0) begin
                hits++;
                if (hits == 3) gap = n - last;
                last = n;
            end
            prev = pick(which);
        end
    endtask : period

    initial begin
        int g;
        int edges;
        int c0;
        int c2;
        logic v;
        logic prev;
        logic [7:0] d;
        logic [7:0] lo;
        rstn = 1'b0;
        base_oscillator = 1'b0;
        scp_tone_gate = 1'b0;
        seed = 32'h3A88;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        check("outputs in reset", 3'h0, {irq0, refresh_req, speaker});

        u_host.io_read(IO_BASE + 10'h003, v, d);
        check("control read valid", 1, v);
        check("control read data", CTL_READ_VAL, d);
        u_host.io_read(10'h03F, v, d);
        check("below window valid", 0, v);
        u_host.io_read(10'h060, v, d);
        check("above window valid", 0, v);
        u_host.io_read(IO_LAST, v, d);
        check("last port valid", 1, v);
        check("last port data", CTL_READ_VAL, d);
        $display("test decode done");

        c0 = 2 + ($unsigned($random(seed)) % 30);
        c2 = 5 + ($unsigned($random(seed)) % 30);
        @(posedge core_clk);
        scp_tone_gate <= 1'b1;
        u_host.load_channel(IO_BASE, 2'h0, 8'h34, c0[15:0]);
        u_host.program_refresh();
        // Aliased window copy reaches the same four ports
        u_host.load_channel(10'h058, 2'h2, 8'hB6, c2[15:0]);
        period(0, g);
        check("tick period", model_period(2, c0), g);
        period(1, g);
        check("refresh period", model_period(2, 18), g);
        @(posedge core_clk);
        #1;
        check("refresh pulse width", 0, refresh_req);
        period(2, g);
        check("tone period", model_period(3, c2), g);
        $display("test channels done");

        u_host.io_write(IO_BASE + 10'h003, 8'h40);
        u_host.io_read(IO_BASE + 10'h001, v, lo);
        u_host.io_read(IO_BASE + 10'h001, v, d);
        check("latched count in range", 1, ({d, lo} >= 16'h0001 && {d, lo} <= 16'h0012));
        $display("test latch done");

        @(posedge core_clk);
        scp_tone_gate <= 1'b0;
        repeat (200) @(posedge core_clk);
        #1;
        prev = speaker;
        edges = 0;
        repeat (3 * model_period(3, c2)) begin
            @(posedge core_clk);
            #1;
            if (speaker !== prev) edges++;
            prev = speaker;
        end
        check("tone edges with gate low", 0, edges);
        @(posedge core_clk);
        scp_tone_gate <= 1'b1;
        period(2, g);
        check("tone period after gate", model_period(3, c2), g);
        $display("test gate done");
        stop_test();
    end
endmodule : stc_timer_test
